//--- sgmii_autoneg_mgmt_regs.sv
// Management frame slave and per-channel auto-negotiation register set
`timescale 1ns/1ns

module sgmii_autoneg_mgmt_regs
	import sgmii_mgmt_pkg::*;
#(
	parameter logic [4:0]  PHY_ADDR_BASE = 5'h00,
	parameter logic [15:0] IDENT_HIGH    = 16'h0000,  // Arbitrary value
	parameter logic [15:0] IDENT_LOW     = 16'h0000   // Arbitrary value
) (
	input  wire logic       i_sys_clk,
	input  wire logic       i_reset,
	input  wire logic       i_phy_mode,
	input  wire logic       i_mdc,
	input  wire logic       i_mdio_i,
	output logic            o_mdio_o,
	output logic            o_mdio_oe_n,
	input  wire an_status_s i_an_status [NUM_CHANNELS],
	output adv_s            o_adv       [NUM_CHANNELS]
);

	typedef struct packed {
		logic                       mdc_meta;
		logic                       mdc_sync;
		logic                       mdc_prev;
		logic                       mdio_meta;
		logic                       mdio_sync;
		frame_state_e               state;
		logic [3:0]                 cnt;
		logic [12:0]                hdr;
		logic [15:0]                shift;
		logic                       drive;
		logic                       out_bit;
		chan_s [NUM_CHANNELS-1:0]   chan;
	} state_s;

	state_s q;
	state_s d;

	logic                           mdc_rise;
	logic [1:0]                     hdr_op;
	logic [4:0]                     hdr_phy;
	logic [4:0]                     hdr_reg;
	logic [4:0]                     chan_off;
	logic                           chan_hit;
	logic [$clog2(NUM_CHANNELS)-1:0] chan_idx;
	logic [15:0]                    rd_value;
	logic                           rd_expansion;
	logic                           wr_commit;
	logic                           wr_advertise;
	logic                           is_read;
	logic                           is_write;
	logic                           ta_first;
	logic                           data_end;
	logic [15:0]                    wr_word;
	logic [15:0]                    adv_word;
	logic [15:0]                    partner_word;
	logic [15:0]                    expansion_word;
	logic [NUM_CHANNELS-1:0]        page_clear;
	logic [NUM_CHANNELS-1:0]        page_next;
	logic [NUM_CHANNELS-1:0]        adv_wr;
	adv_s                           wr_fields;
	chan_s [NUM_CHANNELS-1:0]       chan_next;

	assign mdc_rise = q.mdc_sync & ~q.mdc_prev;
	// Header shifts in ST bit 1, opcode, PHY address and register address
	assign hdr_op   = q.hdr[11:10];
	assign hdr_phy  = q.hdr[9:5];
	assign hdr_reg  = q.hdr[4:0];
	assign chan_off = hdr_phy - PHY_ADDR_BASE;
	assign chan_hit = chan_off < 5'(NUM_CHANNELS);
	assign chan_idx = chan_off[$clog2(NUM_CHANNELS)-1:0];
	assign is_read  = (hdr_op == OP_READ) && chan_hit;
	assign is_write = (hdr_op == OP_WRITE) && chan_hit;
	assign ta_first = mdc_rise && (q.state == ST_TA) && (q.cnt == 4'd0);
	assign data_end = mdc_rise && (q.state == ST_DATA) && (q.cnt == DATA_LAST);
	assign wr_word  = {q.shift[14:0], q.mdio_sync};

	// Advertisement word of the addressed channel as seen in PHY mode
	always_comb begin
		chan_s c;
		c                                   = q.chan[chan_idx];
		adv_word                            = 16'h0000;
		adv_word[BIT_LINK]                  = c.adv.link;
		adv_word[BIT_ACK]                   = c.ack;
		adv_word[BIT_DUPLEX]                = c.adv.duplex;
		adv_word[BIT_SPEED_HI:BIT_SPEED_LO] = c.adv.speed;
		adv_word[BIT_ALWAYS_ONE]            = 1'b1;
	end

	// Partner ability word of the addressed channel
	always_comb begin
		chan_s c;
		c                                       = q.chan[chan_idx];
		partner_word                            = 16'h0000;
		partner_word[BIT_LINK]                  = c.lp_link;
		partner_word[BIT_ACK]                   = c.ack;
		partner_word[BIT_DUPLEX]                = c.lp_duplex;
		partner_word[BIT_SPEED_HI:BIT_SPEED_LO] = c.lp_speed;
		partner_word[BIT_ALWAYS_ONE]            = 1'b1;
	end

	// Expansion word of the addressed channel
	always_comb begin
		expansion_word              = 16'h0000;
		expansion_word[BIT_NP_ABLE] = 1'b1;
		expansion_word[BIT_PAGE_RX] = q.chan[chan_idx].page_rx;
	end

	// Read value for the addressed channel and register; unmapped numbers read zero
	always_comb begin
		case (hdr_reg)
			REG_IDENT_HIGH:  rd_value = IDENT_HIGH;
			REG_IDENT_LOW:   rd_value = IDENT_LOW;
			REG_ADVERTISE:   rd_value = i_phy_mode ? adv_word : MAC_ADV_VALUE;
			REG_PARTNER:     rd_value = partner_word;
			REG_EXPANSION:   rd_value = expansion_word;
			// Next page exchange is not supported, so writes never reach this value
			REG_NP_TRANSMIT: rd_value = NP_TX_DEFAULT;
			default:         rd_value = 16'h0000;
		endcase
	end

	// The flag clears in the cycle the read word is loaded, so the loaded word still shows it
	assign rd_expansion = ta_first && is_read && (hdr_reg == REG_EXPANSION);
	assign wr_commit    = data_end && is_write;
	assign wr_advertise = wr_commit && (hdr_reg == REG_ADVERTISE) && i_phy_mode;

	// Per-channel strobes keep the channel decode out of the register update
	always_comb begin
		for (int i = 0; i < NUM_CHANNELS; i++) begin
			page_clear[i] = rd_expansion && (chan_idx == i[$clog2(NUM_CHANNELS)-1:0]);
			adv_wr[i]     = wr_advertise && (chan_idx == i[$clog2(NUM_CHANNELS)-1:0]);
		end
	end

	// A page arriving in the clearing cycle keeps the flag set
	always_comb begin
		for (int i = 0; i < NUM_CHANNELS; i++) begin
			page_next[i] = q.chan[i].page_rx;
			if (page_clear[i]) begin
				page_next[i] = 1'b0;
			end
			if (i_an_status[i].page_rx) begin
				page_next[i] = 1'b1;
			end
		end
	end

	// Only the writable advertisement fields are kept from a written word
	always_comb begin
		wr_fields        = '0;
		wr_fields.link   = wr_word[BIT_LINK];
		wr_fields.duplex = wr_word[BIT_DUPLEX];
		wr_fields.speed  = wr_word[BIT_SPEED_HI:BIT_SPEED_LO];
	end

	// Status from the negotiation logic is registered once; flags and writes merge in here
	always_comb begin
		for (int i = 0; i < NUM_CHANNELS; i++) begin
			chan_next[i]           = q.chan[i];
			chan_next[i].ack       = i_an_status[i].ack;
			chan_next[i].lp_link   = i_an_status[i].lp_link;
			chan_next[i].lp_duplex = i_an_status[i].lp_duplex;
			chan_next[i].lp_speed  = i_an_status[i].lp_speed;
			chan_next[i].page_rx   = page_next[i];
			if (adv_wr[i]) begin
				chan_next[i].adv = wr_fields;
			end
		end
	end

	always_comb begin
		d           = q;
		d.mdc_meta  = i_mdc;
		d.mdc_sync  = q.mdc_meta;
		d.mdc_prev  = q.mdc_sync;
		d.mdio_meta = i_mdio_i;
		d.mdio_sync = q.mdio_meta;
		d.chan      = chan_next;

		if (mdc_rise) begin
			case (q.state)
				// Preamble is optional: a zero after idle ones is the start bit
				ST_IDLE: begin
					if (!q.mdio_sync) begin
						d.state = ST_HDR;
						d.cnt   = 4'd0;
					end
				end
				ST_HDR: begin
					d.hdr = {q.hdr[11:0], q.mdio_sync};
					d.cnt = q.cnt + 4'd1;
					if (q.cnt == 4'd0 && !q.mdio_sync) begin
						d.state = ST_IDLE;
					end else if (q.cnt == HDR_BITS - 4'd1) begin
						d.state = ST_TA;
						d.cnt   = 4'd0;
					end
				end
				ST_TA: begin
					d.cnt = q.cnt + 4'd1;
					if (q.cnt == 4'd0) begin
						// The word is loaded once here; later bits never see the cleared flag
						d.shift   = rd_value;
						d.drive   = is_read;
						d.out_bit = 1'b0;
					end else begin
						d.state   = ST_DATA;
						d.cnt     = 4'd0;
						// The data line stays low whenever the pin is released
						d.out_bit = q.drive & q.shift[15];
						d.shift   = {q.shift[14:0], 1'b0};
					end
				end
				ST_DATA: begin
					d.cnt = q.cnt + 4'd1;
					if (hdr_op == OP_READ) begin
						d.out_bit = q.drive & q.shift[15];
						d.shift   = {q.shift[14:0], 1'b0};
					end else begin
						d.shift = {q.shift[14:0], q.mdio_sync};
					end
					if (q.cnt == DATA_LAST) begin
						d.state   = ST_IDLE;
						d.drive   = 1'b0;
						d.out_bit = 1'b0;
					end
				end
				default: begin
					d.state = ST_IDLE;
					d.drive = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			q         <= '0;
			q.mdc_prev <= 1'b1;
			q.state   <= ST_IDLE;
			for (int i = 0; i < NUM_CHANNELS; i++) begin
				q.chan[i].lp_link <= LP_LINK_RESET;
			end
		end else begin
			q <= d;
		end
	end

	assign o_mdio_o    = q.out_bit;
	assign o_mdio_oe_n = ~q.drive;

	always_comb begin
		for (int i = 0; i < NUM_CHANNELS; i++) begin
			o_adv[i] = q.chan[i].adv;
		end
	end

endmodule // sgmii_autoneg_mgmt_regs

//--- sgmii_mgmt_pkg.sv
// Constants and carrier types for the per-channel management register set
package sgmii_mgmt_pkg;

	localparam int          NUM_CHANNELS     = 4;

	// Register numbers carried in the five-bit address field of a frame
	localparam logic [4:0]  REG_IDENT_HIGH   = 5'h02;
	localparam logic [4:0]  REG_IDENT_LOW    = 5'h03;
	localparam logic [4:0]  REG_ADVERTISE    = 5'h04;
	localparam logic [4:0]  REG_PARTNER      = 5'h05;
	localparam logic [4:0]  REG_EXPANSION    = 5'h06;
	localparam logic [4:0]  REG_NP_TRANSMIT  = 5'h07;

	// Frame opcodes and field sizes
	localparam logic [1:0]  OP_WRITE         = 2'b01;
	localparam logic [1:0]  OP_READ          = 2'b10;
	localparam logic [3:0]  HDR_BITS         = 4'd13;
	localparam logic [3:0]  DATA_LAST        = 4'd15;

	// Field positions shared by advertisement and partner ability, then the expansion word flags
	localparam int          BIT_LINK         = 15;
	localparam int          BIT_ACK          = 14;
	localparam int          BIT_DUPLEX       = 12;
	localparam int          BIT_SPEED_HI     = 11;
	localparam int          BIT_SPEED_LO     = 10;
	localparam int          BIT_ALWAYS_ONE   = 0;
	localparam int          BIT_NP_ABLE      = 2;
	localparam int          BIT_PAGE_RX      = 1;

	// Speed codes
	localparam logic [1:0]  SPEED_10M        = 2'b00;
	localparam logic [1:0]  SPEED_100M       = 2'b01;
	localparam logic [1:0]  SPEED_1G         = 2'b10;

	// Fixed values and reset values
	localparam logic [15:0] MAC_ADV_VALUE    = 16'h0001;
	localparam logic [15:0] NP_TX_DEFAULT    = 16'h2001;
	localparam logic        LP_LINK_RESET    = 1'b1;

	// Inputs from the auto-negotiation logic, one set per channel
	typedef struct packed {
		logic       page_rx;
		logic       ack;
		logic       lp_link;
		logic       lp_duplex;
		logic [1:0] lp_speed;
	} an_status_s;

	// Advertised abilities in PHY mode, one set per channel
	typedef struct packed {
		logic       link;
		logic       duplex;
		logic [1:0] speed;
	} adv_s;

	typedef struct packed {
		adv_s       adv;
		logic       ack;
		logic       page_rx;
		logic       lp_link;
		logic       lp_duplex;
		logic [1:0] lp_speed;
	} chan_s;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HDR  = 2'b01,
		ST_TA   = 2'b11,
		ST_DATA = 2'b10
	} frame_state_e;

endpackage

//--- sgmii_mgmt_checker_assertions.sv
// Port-level checks for the management register block
`timescale 1ns/1ns
module sgmii_mgmt_checker
	import sgmii_mgmt_pkg::*;
(
	input wire logic       i_sys_clk,
	input wire logic       i_reset,
	input wire logic       i_phy_mode,
	input wire logic       i_mdc,
	input wire logic       i_mdio_i,
	input wire logic       o_mdio_o,
	input wire logic       o_mdio_oe_n,
	input wire an_status_s i_an_status [NUM_CHANNELS],
	input wire adv_s       o_adv       [NUM_CHANNELS]
);
	localparam int DRIVE_MAX = 160;
	logic [15:0] adv_all;
	assign adv_all = {o_adv[3], o_adv[2], o_adv[1], o_adv[0]};
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	property p_rst; $fell(i_reset) |-> o_mdio_oe_n && adv_all == 16'h0000; endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_idle; o_mdio_oe_n |-> !o_mdio_o; endproperty
	a_idle: assert property (p_idle) else $error("data while released");
	// Bits move only after an mdc rise, so the low half stays quiet
	property p_mid; $fell(i_mdc) |=> ($stable(o_mdio_o) && $stable(o_mdio_oe_n))[*2]; endproperty
	a_mid: assert property (p_mid) else $error("bit moved mid period");
	property p_mac; !i_phy_mode |=> $stable(adv_all); endproperty
	a_mac: assert property (p_mac) else $error("adv moved in mac mode");
	property p_one; $changed(adv_all) |-> $onehot({$changed(o_adv[3]), $changed(o_adv[2]),
		$changed(o_adv[1]), $changed(o_adv[0])}); endproperty
	a_one: assert property (p_one) else $error("several channels written");
	property p_quiet; $changed(adv_all) |-> o_mdio_oe_n && i_phy_mode; endproperty
	a_quiet: assert property (p_quiet) else $error("adv moved while driving");
	property p_start; $fell(o_mdio_oe_n) |-> !o_mdio_o ##1 (!o_mdio_oe_n)[*6]; endproperty
	a_start: assert property (p_start) else $error("turnaround wrong");
	property p_end; $fell(o_mdio_oe_n) |-> ##[1:DRIVE_MAX] o_mdio_oe_n; endproperty
	a_end: assert property (p_end) else $error("drive not released");
	c_read: cover property ($fell(o_mdio_oe_n));
	c_write: cover property ($changed(adv_all));
	c_mac: cover property (!i_phy_mode && $fell(o_mdio_oe_n));
endmodule // sgmii_mgmt_checker
bind sgmii_autoneg_mgmt_regs sgmii_mgmt_checker u_chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
	.i_phy_mode(i_phy_mode), .i_mdc(i_mdc), .i_mdio_i(i_mdio_i), .o_mdio_o(o_mdio_o),
	.o_mdio_oe_n(o_mdio_oe_n), .i_an_status(i_an_status), .o_adv(o_adv));

//--- mdio_master_model.sv
// Station management master that sends frames on the link
`timescale 1ns/1ns
module mdio_master_model
	import sgmii_mgmt_pkg::*;
(
	input  wire logic i_mdio_o,
	input  wire logic i_mdio_oe_n,
	output logic      o_mdc,
	output logic      o_mdio
);
	logic drv = 1'b1;
	logic men = 1'b0;
	initial o_mdc = 1'b0;
	// Pull-up holds the line high when nobody drives
	assign o_mdio = !i_mdio_oe_n ? i_mdio_o : (men ? drv : 1'b1);
	task automatic frame(input logic [1:0] op, input logic [4:0] ph, input logic [4:0] rg,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [33:0] v;
		v = {4'b1101, op, ph, rg, 2'b10, wd};
		for (int i = 33; i >= 0; i--) begin
			o_mdc = 1'b0;
			drv = v[i];
			men = i >= 18 || op == OP_WRITE;
			#200;
			o_mdc = 1'b1;
			if (i < 16)
				rd[i] = o_mdio;
			#200;
		end
		o_mdc = 1'b0;
		men = 1'b0;
		#400;
	endtask
endmodule // mdio_master_model

//--- sgmii_autoneg_mgmt_regs_tb.sv
// Self-checking bench for the management register set
`timescale 1ns/1ns
module sgmii_autoneg_mgmt_regs_tb
	import sgmii_mgmt_pkg::*;
;
	localparam logic [15:0] ID_HI = 16'h5a5a; // Arbitrary value
	localparam logic [15:0] ID_LO = 16'hc3c3; // Arbitrary value
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        mode = 1'b0;
	logic        mdc;
	logic        mdio;
	logic        mdio_o;
	logic        mdio_oe_n;
	an_status_s  st [NUM_CHANNELS];
	adv_s        adv [NUM_CHANNELS];
	logic [15:0] rd;
	int          errors = 0;
	int          num_checks = 0;
	initial forever #25 clk = ~clk;
	sgmii_autoneg_mgmt_regs #(.PHY_ADDR_BASE(5'h00), .IDENT_HIGH(ID_HI), .IDENT_LOW(ID_LO)) dut (
		.i_sys_clk(clk), .i_reset(rst), .i_phy_mode(mode), .i_mdc(mdc), .i_mdio_i(mdio),
		.o_mdio_o(mdio_o), .o_mdio_oe_n(mdio_oe_n), .i_an_status(st), .o_adv(adv));
	mdio_master_model u_m (.i_mdio_o(mdio_o), .i_mdio_oe_n(mdio_oe_n), .o_mdc(mdc), .o_mdio(mdio));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdr(input logic [4:0] ph, input logic [4:0] rg, input logic [15:0] exp);
		u_m.frame(OP_READ, ph, rg, 16'h0000, rd);
		chk(rd, exp);
	endtask
	task automatic wrr(input logic [4:0] ph, input logic [4:0] rg, input logic [15:0] d);
		logic [15:0] x;
		u_m.frame(OP_WRITE, ph, rg, d, x);
	endtask
	task automatic do_reset(input logic m);
		@(posedge clk) #1;
		rst = 1'b1;
		mode = m;
		repeat (12) @(posedge clk);
		#1 rst = 1'b0;
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic t_mac;
		wrr(5'h00, REG_ADVERTISE, 16'hffff);
		rdr(5'h00, REG_ADVERTISE, 16'h0001);
		wrr(5'h00, REG_IDENT_HIGH, 16'hffff);
		rdr(5'h00, REG_IDENT_HIGH, ID_HI);
		rdr(5'h03, REG_IDENT_LOW, ID_LO);
	endtask
	task automatic t_adv;
		rdr(5'h01, REG_ADVERTISE, 16'h0001);
		wrr(5'h01, REG_ADVERTISE, 16'hffff);
		rdr(5'h01, REG_ADVERTISE, 16'h9c01);
		for (int s = 0; s < 3; s++) begin
			wrr(5'h01, REG_ADVERTISE, {4'h1, s[1:0], 10'h000});
			rdr(5'h01, REG_ADVERTISE, {4'h1, s[1:0], 10'h001});
			chk({12'h000, adv[1]}, {12'h000, 2'b01, s[1:0]});
			chk({12'h000, adv[0]}, 16'h0000);
		end
	endtask
	task automatic t_partner;
		@(posedge clk) #1;
		st[2] = an_status_s'(6'h1a);
		wrr(5'h02, REG_PARTNER, 16'hffff);
		rdr(5'h02, REG_PARTNER, 16'hc801);
		rdr(5'h02, REG_ADVERTISE, 16'h4001);
		rdr(5'h03, REG_PARTNER, 16'h8001);
	endtask
	task automatic t_rest;
		@(posedge clk) #1;
		st[0].page_rx = 1'b1;
		@(posedge clk) #1;
		st[0].page_rx = 1'b0;
		rdr(5'h00, REG_EXPANSION, 16'h0006);
		rdr(5'h00, REG_EXPANSION, 16'h0004);
		rdr(5'h03, REG_NP_TRANSMIT, 16'h2001);
		wrr(5'h03, REG_NP_TRANSMIT, 16'hdfff);
		rdr(5'h03, REG_NP_TRANSMIT, 16'h2001);
		rdr(5'h00, 5'h08, 16'h0000);
		wrr(5'h04, REG_ADVERTISE, 16'hffff);
		rdr(5'h04, REG_IDENT_HIGH, 16'hffff);
		rdr(5'h00, REG_ADVERTISE, 16'h0001);
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		st = '{default: an_status_s'(6'h08)};
		do_reset(1'b0);
		t_mac;
		do_reset(1'b1);
		t_adv;
		t_partner;
		t_rest;
		wrap_up;
	end
	initial begin
		#2_000_000;
		errors++;
		wrap_up;
	end
endmodule // sgmii_autoneg_mgmt_regs_tb
